// file: crfss_consts.svh
// constants and functional notes for the processor register file block
// Functional notes
// RQ1: eight general registers, thirty-two bits each
// RQ2: byte/word operands touch only low bits; dedicated register writes ignore the size
// RQ3: program counter holds current instruction start
// RQ4: program counter and frame pointer top byte zero
// RQ5: both stack pointers keep 24 bits only
// RQ6: stack select bit picks interrupt or user pointer
// RQ7: push predecrements active pointer by length
// RQ8: pop returns address then postincrements pointer
// RQ9: interrupt stack pointer marks its stack top
// RQ10: user stack pointer marks its stack top
// RQ11: frame pointer loaded on enter, restored exit
// RQ12: frame pointer equals saved old frame address
// RQ13: global base pointer locates module globals
// RQ14: sixteen registers: eight general, eight dedicated
// RQ15: pointers are 24 bits, flat 16 MB; the global base pointer is kept at 32 bits
// RQ16: interrupt or trap entry clears stack select
// RQ17: pointer writes keep bits 23 to 0; global base pointer writes keep all 32 bits
`ifndef CRFSS_CONSTS_SVH
`define CRFSS_CONSTS_SVH
`define CRFSS_DATA_W      32
`define CRFSS_PTR_W       24
`define CRFSS_NUM_GPR     8
`define CRFSS_ADDR_W      4
// register indices: 0..7 general, 8..15 dedicated
`define CRFSS_IDX_PC      4'h8
`define CRFSS_IDX_ISP     4'h9
`define CRFSS_IDX_USP     4'hA
`define CRFSS_IDX_FP      4'hB
`define CRFSS_IDX_GBP     4'hC
`define CRFSS_IDX_ASP     4'hD
`define CRFSS_IDX_STAT    4'hE
`define CRFSS_IDX_RSVD    4'hF
`define CRFSS_RST_VAL     32'h0000_0000
`define CRFSS_PTR_MASK    32'h00FF_FFFF
`define CRFSS_BYTE_MASK   32'h0000_00FF
`define CRFSS_WORD_MASK   32'h0000_FFFF
`define CRFSS_SIZE_BYTE   2'h0
`define CRFSS_SIZE_WORD   2'h1
`define CRFSS_SIZE_DWORD  2'h3
`endif

// file: crfss_merge.sv
// merge a partial-width operand into a 32-bit register value
`timescale 1ns/100ps
`include "crfss_consts.svh"
module crfss_merge
   import crfss_pkg::*;
(
   input  wire logic [31:0] i_old,    // current contents
   input  wire logic [31:0] i_new,    // operand as written
   input  wire logic [1:0]  i_size,   // operand size code
   output logic      [31:0] o_merged  // result to store
);
   logic [31:0] mask; // lanes that the operand reaches
   // narrow operands leave upper bits untouched
   always_comb begin
      case (i_size)
         `CRFSS_SIZE_BYTE: mask = `CRFSS_BYTE_MASK; // RQ2
         `CRFSS_SIZE_WORD: mask = `CRFSS_WORD_MASK; // RQ2
         default:          mask = ~`CRFSS_RST_VAL;
      endcase
      o_merged = (i_old & ~mask) | (i_new & mask);
   end
endmodule : crfss_merge

// file: crfss_pkg.sv
// types shared by the register file block
package crfss_pkg;
   // operand size encodings, length in bytes minus one
   typedef enum logic [1:0] {
      CRFSS_SZ_BYTE  = 2'h0,
      CRFSS_SZ_WORD  = 2'h1,
      CRFSS_SZ_DWORD = 2'h3
   } crfss_size_type;
endpackage : crfss_pkg

// file: crfss_regfile.sv
// programming-model register file with stack pointer selection
`timescale 1ns/100ps
`include "crfss_consts.svh"
module crfss_regfile
   import crfss_pkg::*;
(
   input  wire logic        i_clock,      // core clock
   input  wire logic        i_rstn,       // sync reset, active low
   // software register port
   input  wire logic [3:0]  i_addr,       // register index
   input  wire logic [31:0] i_wdata,      // write data
   input  wire logic [1:0]  i_wsize,      // write operand size
   input  wire logic        i_wr,         // write strobe
   input  wire logic        i_rd,         // read strobe
   output logic      [31:0] o_rdata,      // read data, cycle after i_rd
   // pipeline controls
   input  wire logic        i_pc_load,    // new instruction start
   input  wire logic [31:0] i_pc_value,   // its address
   input  wire logic        i_push,       // push request
   input  wire logic        i_pop,        // pop request
   input  wire logic [1:0]  i_stk_size,   // stack operand size
   input  wire logic        i_trap_entry, // interrupt or trap entry
   input  wire logic        i_sel_wr,     // load stack select bit
   input  wire logic        i_sel_value,  // its value
   input  wire logic        i_fp_load,    // enter/exit frame load
   output logic      [31:0] o_stack_addr, // address for stack access
   output logic             o_stack_sel,  // current stack select bit
   output logic      [31:0] o_pc         // current program counter
);
   ////////////////////////////////////////////////////////////////////
   // storage
   logic [31:0] gpr_ff [`CRFSS_NUM_GPR]; // general registers
   logic [23:0] pc_ff;                    // program counter
   logic [23:0] isp_ff;                   // interrupt stack pointer
   logic [23:0] usp_ff;                   // user stack pointer
   logic [23:0] fp_ff;                    // frame pointer
   logic [31:0] gbp_ff;                   // global base pointer
   logic        sel_ff;                   // stack select bit
   logic [31:0] merged;                   // partial write result
   logic [31:0] rd_mux;                   // read selection
   logic [23:0] act_sp;                   // active stack pointer
   logic [23:0] len;                      // stack operand length
   logic [23:0] nxt_sp;                   // pointer after push or pop
   logic        stk_op;                   // exactly one of push or pop this cycle
   logic        wr_sp;                    // software writes active sp

   // operand length in bytes from size code
   function automatic logic [23:0] size_len(input logic [1:0] s);
      size_len = {22'h0, s} + 24'h00_0001;
   endfunction : size_len

   // zero-extend a 24-bit pointer
   function automatic logic [31:0] ext(input logic [23:0] p);
      ext = {8'h00, p};
   endfunction : ext

   ////////////////////////////////////////////////////////////////////
   // partial-width merge on the addressed general register
   crfss_merge u_merge (
      .i_old    (gpr_ff[i_addr[2:0]]),
      .i_new    (i_wdata),
      .i_size   (i_wsize),
      .o_merged (merged)
   );

   // stack arithmetic
   always_comb begin
      act_sp = sel_ff ? usp_ff : isp_ff;                 // RQ6
      len    = size_len(i_stk_size);
      stk_op = i_push ^ i_pop;
      nxt_sp = i_push ? (act_sp - len) : (act_sp + len); // RQ7 RQ8
      wr_sp  = i_wr && (i_addr == `CRFSS_IDX_ASP);
   end

   ////////////////////////////////////////////////////////////////////
   // general registers, one generate slice each
   genvar g;
   generate
      for (g = 0; g < `CRFSS_NUM_GPR; g++) begin : g_gpr
         always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
               gpr_ff[g] <= `CRFSS_RST_VAL;
            end else if (i_wr && i_addr == 4'(g)) begin
               gpr_ff[g] <= merged; // RQ1 RQ2
            end
         end
      end
   endgenerate

   // program counter, pipeline load wins over software write
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         pc_ff <= 24'h00_0000;
      end else if (i_pc_load) begin
         pc_ff <= i_pc_value[23:0]; // RQ3 RQ4
      end else if (i_wr && i_addr == `CRFSS_IDX_PC) begin
         pc_ff <= i_wdata[23:0]; // RQ17
      end
   end

   // stack select: trap entry clears, overriding explicit load
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         sel_ff <= 1'b0;
      end else if (i_trap_entry) begin
         sel_ff <= 1'b0; // RQ16
      end else if (i_sel_wr) begin
         sel_ff <= i_sel_value;
      end else if (i_wr && i_addr == `CRFSS_IDX_STAT) begin
         sel_ff <= i_wdata[0];
      end
   end

   // interrupt stack pointer; stack op beats software write
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         isp_ff <= 24'h00_0000;
      end else if (stk_op && !sel_ff) begin
         isp_ff <= nxt_sp; // RQ9 RQ7 RQ8
      end else if ((i_wr && i_addr == `CRFSS_IDX_ISP) || (wr_sp && !sel_ff)) begin
         isp_ff <= i_wdata[23:0]; // RQ5 RQ17
      end
   end

   // user stack pointer
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         usp_ff <= 24'h00_0000;
      end else if (stk_op && sel_ff) begin
         usp_ff <= nxt_sp; // RQ10 RQ7 RQ8
      end else if ((i_wr && i_addr == `CRFSS_IDX_USP) || (wr_sp && sel_ff)) begin
         usp_ff <= i_wdata[23:0]; // RQ5 RQ17
      end
   end

   // frame pointer: enter loads save address, exit loads restored value
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         fp_ff <= 24'h00_0000;
      end else if (i_fp_load) begin
         fp_ff <= i_wdata[23:0]; // RQ11 RQ12 RQ4
      end else if (i_wr && i_addr == `CRFSS_IDX_FP) begin
         fp_ff <= i_wdata[23:0]; // RQ17
      end
   end

   // global base pointer, full width kept as stored
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         gbp_ff <= `CRFSS_RST_VAL;
      end else if (i_wr && i_addr == `CRFSS_IDX_GBP) begin
         gbp_ff <= i_wdata; // RQ13
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read decode over sixteen indices
   always_comb begin
      case (i_addr)
         `CRFSS_IDX_PC:   rd_mux = ext(pc_ff);  // RQ4
         `CRFSS_IDX_ISP:  rd_mux = ext(isp_ff); // RQ5
         `CRFSS_IDX_USP:  rd_mux = ext(usp_ff); // RQ5
         `CRFSS_IDX_FP:   rd_mux = ext(fp_ff);  // RQ4
         `CRFSS_IDX_GBP:  rd_mux = gbp_ff;
         `CRFSS_IDX_ASP:  rd_mux = ext(act_sp); // RQ6
         `CRFSS_IDX_STAT: rd_mux = {31'h0000_0000, sel_ff};
         `CRFSS_IDX_RSVD: rd_mux = `CRFSS_RST_VAL;
         default:         rd_mux = gpr_ff[i_addr[2:0]]; // RQ14
      endcase
   end

   // registered read data, valid only the cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_rdata <= `CRFSS_RST_VAL;
      end else begin
         o_rdata <= i_rd ? rd_mux : `CRFSS_RST_VAL;
      end
   end

   // stack access address: push uses new, pop uses old pointer
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_stack_addr <= `CRFSS_RST_VAL;
      end else if (stk_op) begin
         o_stack_addr <= ext(i_push ? nxt_sp : act_sp); // RQ7 RQ8 RQ15
      end
   end

   // mirrored status outputs
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_stack_sel <= 1'b0;
         o_pc        <= `CRFSS_RST_VAL;
      end else begin
         // same priority as the state flops, so the mirror never lags a status write
         o_stack_sel <= i_trap_entry ? 1'b0 :
                        (i_sel_wr ? i_sel_value :
                        ((i_wr && i_addr == `CRFSS_IDX_STAT) ? i_wdata[0] : sel_ff)); // RQ6 RQ16
         // software pc write must show on the mirror at the same edge
         o_pc        <= ext(i_pc_load ? i_pc_value[23:0] :
                        ((i_wr && i_addr == `CRFSS_IDX_PC) ? i_wdata[23:0] : pc_ff)); // RQ3 RQ4
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_push_dec;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_push && !i_pop && !i_trap_entry) |=> (o_stack_addr == ext($past(act_sp) - $past(len)));
   endproperty
   a_push_dec: assert property (p_push_dec) else $error("push address wrong"); // RQ7

   property p_pop_inc;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_pop && !i_push && !sel_ff) |=> (isp_ff == $past(isp_ff) + $past(len));
   endproperty
   a_pop_inc: assert property (p_pop_inc) else $error("pop increment wrong"); // RQ8

   property p_trap_clear;
      @(posedge i_clock) disable iff (!i_rstn)
      i_trap_entry |=> !sel_ff ##0 !o_stack_sel;
   endproperty
   a_trap_clear: assert property (p_trap_clear) else $error("select not cleared"); // RQ16

   property p_read_top;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_rd && i_addr inside {`CRFSS_IDX_PC, `CRFSS_IDX_FP, `CRFSS_IDX_ISP, `CRFSS_IDX_USP})
         |=> (o_rdata[31:24] == 8'h00);
   endproperty
   a_read_top: assert property (p_read_top) else $error("pointer top byte set"); // RQ4

   property p_byte_keep;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_wr && !i_addr[3] && i_wsize == `CRFSS_SIZE_BYTE)
         |=> (gpr_ff[$past(i_addr[2:0])][31:8] == $past(gpr_ff[i_addr[2:0]][31:8]));
   endproperty
   a_byte_keep: assert property (p_byte_keep) else $error("upper bits changed"); // RQ2

   property p_sel_pick;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_rd && i_addr == `CRFSS_IDX_ASP) |=> (o_rdata == ext($past(sel_ff) ? $past(usp_ff) : $past(isp_ff)));
   endproperty
   a_sel_pick: assert property (p_sel_pick) else $error("wrong stack selected"); // RQ6

   property p_pc_load;
      @(posedge i_clock) disable iff (!i_rstn)
      i_pc_load |=> (o_pc == ext($past(i_pc_value[23:0])));
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("pc not loaded"); // RQ3

   property p_fp_load;
      @(posedge i_clock) disable iff (!i_rstn)
      i_fp_load |=> (fp_ff == $past(i_wdata[23:0]));
   endproperty
   a_fp_load: assert property (p_fp_load) else $error("frame pointer not loaded"); // RQ11

   property p_rd_idle;
      @(posedge i_clock) disable iff (!i_rstn)
      !i_rd |=> (o_rdata == `CRFSS_RST_VAL);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe"); // RQ14

   ////////////////////////////////////////////////////////////////////
   // further checks on pointers, mirrors and general register word writes
   // user stack pop moves the user pointer up by the operand length
   property p_usp_pop_inc;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_pop && !i_push && sel_ff) |=> (usp_ff == $past(usp_ff) + $past(len));
   endproperty
   a_usp_pop_inc: assert property (p_usp_pop_inc) else $error("user pop increment wrong"); // RQ10

   // pop hands out the pointer as it stood before the increment
   property p_pop_addr;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_pop && !i_push) |=> (o_stack_addr == ext($past(act_sp)));
   endproperty
   a_pop_addr: assert property (p_pop_addr) else $error("pop address wrong"); // RQ8

   // push and pop together is no stack operation
   property p_null_stack;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_push && i_pop && !i_wr) |=> ($stable(isp_ff) && $stable(usp_ff));
   endproperty
   a_null_stack: assert property (p_null_stack) else $error("pointer moved on null op"); // RQ7

   // stack addresses never leave the 24-bit space
   property p_addr_top;
      @(posedge i_clock) disable iff (!i_rstn)
      (o_stack_addr[31:24] == 8'h00);
   endproperty
   a_addr_top: assert property (p_addr_top) else $error("stack address top byte set"); // RQ15

   // global base keeps the full word as written
   property p_gbp_full;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_wr && i_addr == `CRFSS_IDX_GBP) |=> (gbp_ff == $past(i_wdata));
   endproperty
   a_gbp_full: assert property (p_gbp_full) else $error("global base not stored"); // RQ13

   // select output always matches the select flop
   property p_sel_mirror;
      @(posedge i_clock) disable iff (!i_rstn)
      (o_stack_sel == sel_ff);
   endproperty
   a_sel_mirror: assert property (p_sel_mirror) else $error("select output lags"); // RQ6

   // pc output always matches the pc flop
   property p_pc_mirror;
      @(posedge i_clock) disable iff (!i_rstn)
      (o_pc == ext(pc_ff));
   endproperty
   a_pc_mirror: assert property (p_pc_mirror) else $error("pc output lags"); // RQ3

   // software frame pointer write keeps only the low 24 bits
   property p_ptr_write;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_wr && i_addr == `CRFSS_IDX_FP && !i_fp_load) |=> (fp_ff == $past(i_wdata[23:0]));
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer write wrong"); // RQ17

   // word operand leaves the upper half alone
   property p_word_keep;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_wr && !i_addr[3] && i_wsize == `CRFSS_SIZE_WORD)
         |=> (gpr_ff[$past(i_addr[2:0])][31:16] == $past(gpr_ff[i_addr[2:0]][31:16]));
   endproperty
   a_word_keep: assert property (p_word_keep) else $error("upper half changed"); // RQ2

   c_push: cover property (@(posedge i_clock) disable iff (!i_rstn) i_push && sel_ff);
   c_pop:  cover property (@(posedge i_clock) disable iff (!i_rstn) i_pop && !sel_ff);
   c_trap: cover property (@(posedge i_clock) disable iff (!i_rstn) i_trap_entry && sel_ff);
   c_fp:   cover property (@(posedge i_clock) disable iff (!i_rstn) i_fp_load);
   c_stat: cover property (@(posedge i_clock) disable iff (!i_rstn) i_wr && i_addr == `CRFSS_IDX_STAT);
endmodule : crfss_regfile

// file: crfss_tb_top.sv
// self-checking bench for the processor register file with stack selection
`timescale 1ns/100ps
module cpu_register_file_stack_select_tb_top
   import crfss_pkg::*;
;
   ////////////////////////////////////////////////////////////////
   logic        i_clock;      // 100 MHz core clock
   logic        i_rstn;       // sync reset, active low
   logic [3:0]  i_addr;       // register index
   logic [31:0] i_wdata;      // write data, also frame load value
   logic [1:0]  i_wsize;      // write operand size
   logic        i_wr;         // write strobe
   logic        i_rd;         // read strobe
   logic [31:0] o_rdata;      // read data
   logic        i_pc_load;    // instruction start load
   logic [31:0] i_pc_value;   // instruction start address
   logic        i_push;       // push request
   logic        i_pop;        // pop request
   logic [1:0]  i_stk_size;   // stack operand size
   logic        i_trap_entry; // trap entry pulse
   logic        i_sel_wr;     // select bit load
   logic        i_sel_value;  // select bit value
   logic        i_fp_load;    // frame load pulse
   logic [31:0] o_stack_addr; // stack access address
   logic        o_stack_sel;  // select bit
   logic [31:0] o_pc;         // program counter
   int          err_total;    // mismatches
   int          check_count;  // comparisons

   crfss_regfile i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wsize(i_wsize), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pc_load(i_pc_load),
      .i_pc_value(i_pc_value), .i_push(i_push), .i_pop(i_pop), .i_stk_size(i_stk_size),
      .i_trap_entry(i_trap_entry), .i_sel_wr(i_sel_wr), .i_sel_value(i_sel_value),
      .i_fp_load(i_fp_load), .o_stack_addr(o_stack_addr), .o_stack_sel(o_stack_sel), .o_pc(o_pc));

   ////////////////////////////////////////////////////////////////
   // free-running clock, 10 ns period
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // compare and count; unknowns never match
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] s);
      @(posedge i_clock);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d; i_wsize <= s;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data checked in the following cycle only
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask : rd

   // one stack operation, address checked once it has landed
   task stk(input logic ps, input logic pp, input logic [1:0] sz, input logic [31:0] e);
      @(posedge i_clock);
      i_push <= ps; i_pop <= pp; i_stk_size <= sz;
      @(posedge i_clock);
      i_push <= 1'b0; i_pop <= 1'b0;
      #1 chk(o_stack_addr, e);
   endtask : stk

   // single place where the run ends
   task close_out;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // watchdog: tests need well under 2000 cycles
   initial begin
      #50000;
      err_total++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0; check_count = 0;
      i_rstn = 1'b0; i_addr = 4'h0; i_wdata = 32'h0000_0000; i_wsize = 2'h0; i_wr = 1'b0; i_rd = 1'b0;
      i_pc_load = 1'b0; i_pc_value = 32'h0000_0000; i_push = 1'b0; i_pop = 1'b0; i_stk_size = 2'h0;
      i_trap_entry = 1'b0; i_sel_wr = 1'b0; i_sel_value = 1'b0; i_fp_load = 1'b0;
      repeat (4) @(posedge i_clock);
      i_rstn <= 1'b1;
      // every index reads zero after reset
      for (int k = 0; k < 16; k++) rd(4'(k), 32'h0000_0000);
      $display("test reset done");
      // partial-width writes keep the upper bits
      for (int k = 0; k < 8; k++) wr(4'(k), 32'h1111_1111 * k + 32'h8000_0000, CRFSS_SZ_DWORD);
      for (int k = 0; k < 8; k++) rd(4'(k), 32'h1111_1111 * k + 32'h8000_0000);
      wr(4'h3, 32'hFFFF_FFAB, CRFSS_SZ_BYTE);
      rd(4'h3, 32'hB333_33AB);
      wr(4'h3, 32'hFFFF_CDEF, CRFSS_SZ_WORD);
      rd(4'h3, 32'hB333_CDEF);
      $display("test general done");
      // pointer registers drop the top byte, global base keeps it
      wr(4'h8, 32'hFFFF_FFFF, CRFSS_SZ_DWORD);
      rd(4'h8, 32'h00FF_FFFF);
      wr(4'hB, 32'hA5A5_A5A5, CRFSS_SZ_DWORD);
      rd(4'hB, 32'h00A5_A5A5);
      wr(4'hC, 32'hFFFF_FFFF, CRFSS_SZ_DWORD);
      rd(4'hC, 32'hFFFF_FFFF);
      wr(4'hF, 32'h1234_5678, CRFSS_SZ_DWORD);
      rd(4'hF, 32'h0000_0000);
      @(posedge i_clock);
      i_pc_load <= 1'b1; i_pc_value <= 32'hAB12_3456;
      @(posedge i_clock);
      i_pc_load <= 1'b0;
      #1 chk(o_pc, 32'h0012_3456);
      rd(4'h8, 32'h0012_3456);
      $display("test pointers done");
      // interrupt stack: push predecrements, pop postincrements
      wr(4'h9, 32'hAA00_0100, CRFSS_SZ_DWORD);
      rd(4'h9, 32'h0000_0100);
      stk(1'b1, 1'b0, CRFSS_SZ_DWORD, 32'h0000_00FC);
      rd(4'h9, 32'h0000_00FC);
      stk(1'b0, 1'b1, CRFSS_SZ_WORD, 32'h0000_00FC);
      rd(4'h9, 32'h0000_00FE);
      stk(1'b1, 1'b1, CRFSS_SZ_DWORD, 32'h0000_00FC);
      rd(4'h9, 32'h0000_00FE);
      // wrap below zero stays inside 24 bits
      wr(4'h9, 32'h0000_0000, CRFSS_SZ_DWORD);
      stk(1'b1, 1'b0, CRFSS_SZ_BYTE, 32'h00FF_FFFF);
      $display("test interrupt stack done");
      // user stack selected by the select bit
      @(posedge i_clock);
      i_sel_wr <= 1'b1; i_sel_value <= 1'b1;
      @(posedge i_clock);
      i_sel_wr <= 1'b0;
      #1 chk({31'h0, o_stack_sel}, 32'h0000_0001);
      wr(4'hA, 32'hFF00_0200, CRFSS_SZ_DWORD);
      stk(1'b1, 1'b0, CRFSS_SZ_BYTE, 32'h0000_01FF);
      rd(4'hD, 32'h0000_01FF);
      rd(4'h9, 32'h00FF_FFFF);
      rd(4'hE, 32'h0000_0001);
      // trap entry returns to the interrupt stack
      @(posedge i_clock);
      i_trap_entry <= 1'b1;
      @(posedge i_clock);
      i_trap_entry <= 1'b0;
      #1 chk({31'h0, o_stack_sel}, 32'h0000_0000);
      rd(4'hD, 32'h00FF_FFFF);
      $display("test stack select done");
      // frame load on procedure entry, zero-extended
      @(posedge i_clock);
      i_fp_load <= 1'b1; i_wdata <= 32'h1234_5678;
      @(posedge i_clock);
      i_fp_load <= 1'b0;
      rd(4'hB, 32'h0034_5678);
      $display("test frame done");
      // status and active pointer reached through software indices
      wr(4'hE, 32'h0000_0001, CRFSS_SZ_DWORD);
      #1 chk({31'h0, o_stack_sel}, 32'h0000_0001);
      wr(4'hD, 32'hEE00_0300, CRFSS_SZ_DWORD);
      rd(4'hA, 32'h0000_0300);
      rd(4'h9, 32'h00FF_FFFF);
      wr(4'h8, 32'hFF55_AA00, CRFSS_SZ_DWORD);
      #1 chk(o_pc, 32'h0055_AA00);
      wr(4'hE, 32'h0000_0000, CRFSS_SZ_DWORD);
      #1 chk({31'h0, o_stack_sel}, 32'h0000_0000);
      $display("test software index done");
      close_out();
   end
endmodule : cpu_register_file_stack_select_tb_top
